// >>> hw/swp_pkg.sv
// Shared constants and types for the serial protected word store
package swp_pkg;

	// Clock and self-timed program cycle
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_WRITE_NS    = 10000;
	localparam int WRITE_CYC     =
		(T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Array shape and read buffer depth
	localparam int WORDS      = 16;
	localparam int WORD_W     = 16;
	localparam int ADDR_W     = 4;
	localparam int FIFO_DEPTH = 16;

	// Serial frame: start bit, two opcode bits, four address bits
	localparam logic [4:0] CMD_LAST  = 5'h05;
	localparam logic [4:0] DATA_LAST = 5'h0f;
	localparam logic [4:0] WORD_LAST = 5'h0f;

	// Opcode field, bits [5:4] of the frame after the start bit
	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_CLEAR = 2'h3;

	// Extended codes, address bits [3:2] when opcode is OP_EXT; CLEAR_ADDR is the full address for OP_CLEAR
	localparam logic [1:0] EXT_DISABLE = 2'h0;
	localparam logic [1:0] EXT_WRALL   = 2'h1;
	localparam logic [1:0] EXT_ENABLE  = 2'h3;
	localparam logic [3:0] CLEAR_ADDR  = 4'hf;

	// Values after reset
	localparam logic [15:0] MEM_RESET      = 16'hffff;
	localparam logic [3:0]  PR_ADDR_RESET  = 4'h0;
	localparam logic        PR_VALID_RESET = 1'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD  = 3'b001,
		ST_DATA = 3'b010,
		ST_READ = 3'b011,
		ST_DONE = 3'b100
	} swp_state_type;

endpackage

// >>> hw/swp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a flush
module swp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and control
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
		$error("swp_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW:0]      wr_ptr_ff;
	logic [PW:0]      rd_ptr_ff;
	logic             push;
	logic             pop;

	assign in_ready  = !((wr_ptr_ff[PW] != rd_ptr_ff[PW]) &&
		(wr_ptr_ff[PW-1:0] == rd_ptr_ff[PW-1:0]));
	assign out_valid = wr_ptr_ff != rd_ptr_ff;
	assign out_data  = mem_ff[rd_ptr_ff[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else if (ce) begin
			if (flush) begin
				wr_ptr_ff <= '0;
				rd_ptr_ff <= '0;
			end else begin
				if (push)
					wr_ptr_ff <= wr_ptr_ff + 1'b1;
				if (pop)
					rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (ce && push && !flush)
			mem_ff[wr_ptr_ff[PW-1:0]] <= in_data;
	end

	a_fifo_full: assert property (@(posedge clk) disable iff (!rst_n)
		!in_ready |-> out_valid)
		else $error("fifo full while empty");

endmodule // swp_fifo

// >>> hw/swp_eeprom.sv
// Serial word store with write protect, lock and sequential read
// What this block does
// - Sixteen sixteen-bit words, word addressed.
// - Words at or above protect address refuse writes.
// - After lock, no array or protect change.
// - Sequential read streams whole array, one select.
// - Ten instructions: five array, five protect.
// - Write replaces word, no erase first.
// - Program cycle timed internally after acceptance.
// - Busy status shown; controller waits for ready.
module swp_eeprom #(
	parameter int WRITE_CYC  = swp_pkg::WRITE_CYC,
	parameter int FIFO_DEPTH = swp_pkg::FIFO_DEPTH
) (
	// Clock, reset, enable
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Serial link pins
	input  wire logic chip_select_in,
	input  wire logic serial_clock_in,
	input  wire logic serial_data_in,
	output logic      serial_data_out,
	output logic      serial_data_out_en,
	// Enable pins
	input  wire logic program_enable_in,
	input  wire logic protect_enable_in
);
	if (WRITE_CYC < 1 || WRITE_CYC > 65535) begin : g_bad_cyc
		$error("swp_eeprom: WRITE_CYC out of range");
	end

	localparam int WORDS = swp_pkg::WORDS;
	localparam int WW    = swp_pkg::WORD_W;
	localparam int AW    = swp_pkg::ADDR_W;

	logic [4:0]              sync1_ff;
	logic [4:0]              sync2_ff;
	logic                    sk_prev_ff;
	logic                    cs_s, sk_s, di_s, pe_s, pre_s;
	logic                    sk_rise, sk_fall;
	swp_pkg::swp_state_type  state_ff, nxt_state;
	logic [4:0]              bit_cnt_ff;
	logic [5:0]              cmd_sh_ff;
	logic [WW-1:0]           data_sh_ff;
	logic [AW-1:0]           adr_ff;
	logic                    all_ff;
	logic [5:0]              nxt_cmd;
	logic [WW-1:0]           nxt_data;
	logic [1:0]              dec_op;
	logic [AW-1:0]           dec_adr;
	logic                    done_cmd, done_data;
	logic [WW-1:0]           mem_ff [WORDS];
	logic [AW-1:0]           pr_addr_ff;
	logic                    pr_valid_ff, lock_ff;
	logic                    wen_ff, pr_wen_ff;
	logic [WORDS-1:0]        prot_vec, wr_word;
	logic                    mem_go, pr_ok;
	logic                    pr_write_go, pr_clear_go, pr_lock_go;
	logic                    prog_go;
	logic                    busy_ff;
	logic [15:0]             busy_cnt_ff;
	logic                    fetch_on_ff, fetch_pr_ff;
	logic [AW-1:0]           fetch_addr_ff;
	logic                    push_ready, pop, fifo_valid;
	logic [WW-1:0]           push_data, fifo_data;
	logic [WW-1:0]           out_sh_ff;
	logic [4:0]              out_cnt_ff;
	logic [16:0]             busy_len_ff;

	// Pins pass two flip-flops before use
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff   <= 5'h00;
			sync2_ff   <= 5'h00;
			sk_prev_ff <= 1'b0;
		end else if (ce) begin
			sync1_ff   <= {protect_enable_in, program_enable_in,
				serial_data_in, serial_clock_in, chip_select_in};
			sync2_ff   <= sync1_ff;
			sk_prev_ff <= sync2_ff[1];
		end
	end

	assign cs_s    = sync2_ff[0];
	assign sk_s    = sync2_ff[1];
	assign di_s    = sync2_ff[2];
	assign pe_s    = sync2_ff[3];
	assign pre_s   = sync2_ff[4];
	assign sk_rise = sk_s && !sk_prev_ff;
	assign sk_fall = !sk_s && sk_prev_ff;

	assign nxt_cmd   = {cmd_sh_ff[4:0], di_s};
	assign nxt_data  = {data_sh_ff[WW-2:0], di_s};
	assign dec_op    = nxt_cmd[5:4];
	assign dec_adr   = nxt_cmd[3:0];
	assign done_cmd  = sk_rise && state_ff == swp_pkg::ST_CMD &&
		bit_cnt_ff == swp_pkg::CMD_LAST;
	assign done_data = sk_rise && state_ff == swp_pkg::ST_DATA &&
		bit_cnt_ff == swp_pkg::DATA_LAST;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			swp_pkg::ST_IDLE: begin
				if (sk_rise && di_s && !busy_ff)
					nxt_state = swp_pkg::ST_CMD;
			end
			swp_pkg::ST_CMD: begin
				if (done_cmd) begin
					if (dec_op == swp_pkg::OP_READ)
						nxt_state = swp_pkg::ST_READ;
					else if (!pre_s && (dec_op == swp_pkg::OP_WRITE ||
						(dec_op == swp_pkg::OP_EXT &&
						dec_adr[3:2] == swp_pkg::EXT_WRALL)))
						nxt_state = swp_pkg::ST_DATA;
					else
						nxt_state = swp_pkg::ST_DONE;
				end
			end
			swp_pkg::ST_DATA: begin
				if (done_data)
					nxt_state = swp_pkg::ST_DONE;
			end
			swp_pkg::ST_READ, swp_pkg::ST_DONE: nxt_state = state_ff;
			default: nxt_state = swp_pkg::ST_IDLE;
		endcase
		if (!cs_s)
			nxt_state = swp_pkg::ST_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff   <= swp_pkg::ST_IDLE;
			bit_cnt_ff <= 5'h00;
			cmd_sh_ff  <= 6'h00;
			data_sh_ff <= 16'h0000;
			adr_ff     <= 4'h0;
			all_ff     <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
				bit_cnt_ff <= 5'h00;
			else if (sk_rise)
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
			if (sk_rise && state_ff == swp_pkg::ST_CMD)
				cmd_sh_ff <= nxt_cmd;
			if (sk_rise && state_ff == swp_pkg::ST_DATA)
				data_sh_ff <= nxt_data;
			if (done_cmd) begin
				adr_ff <= dec_adr;
				all_ff <= dec_op == swp_pkg::OP_EXT;
			end
		end
	end

	// words at or above the start address are guarded
	for (genvar i = 0; i < WORDS; i++) begin : g_word
		assign prot_vec[i] = pr_valid_ff && (AW'(i) >= pr_addr_ff);
		assign wr_word[i]  = mem_go && (all_ff || adr_ff == AW'(i)) &&
			!prot_vec[i];
	end

	// program enable gates array changes; lock blocks them
	assign mem_go = done_data && wen_ff && pe_s && !lock_ff;
	// protect enable gates protect changes; lock blocks them
	assign pr_ok  = done_cmd && pre_s && pr_wen_ff && !lock_ff;
	assign pr_write_go = pr_ok && dec_op == swp_pkg::OP_WRITE;
	assign pr_clear_go = pr_ok && dec_op == swp_pkg::OP_CLEAR &&
		dec_adr == swp_pkg::CLEAR_ADDR;
	assign pr_lock_go  = pr_ok && dec_op == swp_pkg::OP_EXT &&
		dec_adr[3:2] == swp_pkg::EXT_DISABLE;
	assign prog_go = (|wr_word) || pr_write_go || pr_clear_go || pr_lock_go;

	// Write enable latches
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wen_ff    <= 1'b0;
			pr_wen_ff <= 1'b0;
		end else if (ce && done_cmd && dec_op == swp_pkg::OP_EXT) begin
			if (!pre_s && dec_adr[3:2] == swp_pkg::EXT_ENABLE)
				wen_ff <= 1'b1;
			else if (!pre_s && dec_adr[3:2] == swp_pkg::EXT_DISABLE)
				wen_ff <= 1'b0;
			else if (pre_s && dec_adr[3:2] == swp_pkg::EXT_ENABLE)
				pr_wen_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < WORDS; k++)
				mem_ff[k] <= swp_pkg::MEM_RESET;
		end else if (ce) begin
			for (int k = 0; k < WORDS; k++)
				if (wr_word[k])
					mem_ff[k] <= nxt_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pr_addr_ff  <= swp_pkg::PR_ADDR_RESET;
			pr_valid_ff <= swp_pkg::PR_VALID_RESET;
			lock_ff     <= 1'b0;
		end else if (ce) begin
			if (pr_write_go) begin
				pr_addr_ff  <= dec_adr;
				pr_valid_ff <= 1'b1;
			end else if (pr_clear_go) begin
				pr_valid_ff <= 1'b0;
			end else if (pr_lock_go) begin
				lock_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_ff     <= 1'b0;
			busy_cnt_ff <= 16'h0000;
		end else if (ce) begin
			if (prog_go) begin
				busy_ff     <= 1'b1;
				busy_cnt_ff <= 16'(WRITE_CYC);
			end else if (busy_ff) begin
				busy_cnt_ff <= busy_cnt_ff - 16'h0001;
				if (busy_cnt_ff == 16'h0001)
					busy_ff <= 1'b0;
			end
		end
	end

	// fetch words into the buffer, wrapping through the array
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fetch_on_ff   <= 1'b0;
			fetch_pr_ff   <= 1'b0;
			fetch_addr_ff <= 4'h0;
		end else if (ce) begin
			if (!cs_s) begin
				fetch_on_ff <= 1'b0;
			end else if (done_cmd && dec_op == swp_pkg::OP_READ) begin
				fetch_on_ff   <= 1'b1;
				fetch_pr_ff   <= pre_s;
				fetch_addr_ff <= dec_adr;
			end else if (fetch_on_ff && push_ready) begin
				fetch_addr_ff <= fetch_addr_ff + 4'h1;
				if (fetch_pr_ff)
					fetch_on_ff <= 1'b0;
			end
		end
	end

	assign push_data = fetch_pr_ff ?
		{lock_ff, pr_valid_ff, 10'h000, pr_addr_ff} :
		mem_ff[fetch_addr_ff];
	assign pop = state_ff == swp_pkg::ST_READ && sk_fall &&
		out_cnt_ff == 5'h00 && fifo_valid;

	swp_fifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.flush     (!cs_s),
		.in_valid  (fetch_on_ff),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	// Output shifter, advanced on falling serial clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_sh_ff  <= 16'h0000;
			out_cnt_ff <= 5'h00;
		end else if (ce) begin
			if (!cs_s) begin
				out_cnt_ff <= 5'h00;
			end else if (pop) begin
				out_sh_ff  <= {fifo_data[WW-2:0], 1'b0};
				out_cnt_ff <= swp_pkg::WORD_LAST;
			end else if (state_ff == swp_pkg::ST_READ && sk_fall &&
				out_cnt_ff != 5'h00) begin
				out_sh_ff  <= {out_sh_ff[WW-2:0], 1'b0};
				out_cnt_ff <= out_cnt_ff - 5'h01;
			end
		end
	end

	// data out carries read data or ready status
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serial_data_out    <= 1'b0;
			serial_data_out_en <= 1'b0;
		end else if (ce) begin
			serial_data_out_en <= cs_s;
			if (!cs_s)
				serial_data_out <= 1'b0;
			else if (state_ff == swp_pkg::ST_READ) begin
				if (pop)
					serial_data_out <= fifo_data[WW-1];
				else if (sk_fall && out_cnt_ff != 5'h00)
					serial_data_out <= out_sh_ff[WW-1];
			end else if (nxt_state == swp_pkg::ST_READ)
				serial_data_out <= 1'b0;
			else
				serial_data_out <= !busy_ff;
		end
	end

	// Helper: enabled cycles spent busy
	always_ff @(posedge clk) begin
		if (!rst_n)
			busy_len_ff <= 17'h00000;
		else if (ce)
			busy_len_ff <= busy_ff ? busy_len_ff + 17'h00001 : 17'h00000;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_busy_length: assert property (
		ce && $fell(busy_ff) |-> busy_len_ff == 17'(WRITE_CYC))
		else $error("program cycle length wrong");
	a_busy_ignore: assert property (
		ce && busy_ff && state_ff == swp_pkg::ST_IDLE |=>
		state_ff == swp_pkg::ST_IDLE)
		else $error("instruction started while busy");
	a_status_out: assert property (
		ce && cs_s && state_ff == swp_pkg::ST_DONE &&
		nxt_state == swp_pkg::ST_DONE |=> serial_data_out == !$past(busy_ff))
		else $error("status bit wrong");
	a_protect_hold: assert property (
		ce && mem_go && !all_ff && prot_vec[adr_ff] |=>
		mem_ff[$past(adr_ff)] == $past(mem_ff[adr_ff]))
		else $error("protected word changed");
	a_write_data: assert property (
		ce && mem_go && !all_ff && !prot_vec[adr_ff] |=>
		mem_ff[$past(adr_ff)] == $past(nxt_data))
		else $error("write did not replace word");
	a_lock_freeze: assert property (
		lock_ff |=> lock_ff && $stable(pr_addr_ff) && $stable(pr_valid_ff))
		else $error("protect setting changed after lock");
	a_lock_nowrite: assert property (
		$past(lock_ff) |-> !$rose(busy_ff))
		else $error("program cycle after lock");
	a_seq_next: assert property (
		ce && cs_s && fetch_on_ff && !fetch_pr_ff && push_ready && !done_cmd
		|=> fetch_addr_ff == $past(fetch_addr_ff) + 4'h1)
		else $error("sequential read address skipped");
	a_read_decode: assert property (
		ce && cs_s && done_cmd && dec_op == swp_pkg::OP_READ |=>
		state_ff == swp_pkg::ST_READ && fetch_on_ff)
		else $error("read not decoded");
	a_enable_gate: assert property (
		ce && $rose(busy_ff) |-> $past(pe_s) || $past(pre_s))
		else $error("program without enable pin");

	c_seq_wrap: cover property (fetch_on_ff && fetch_addr_ff == 4'hf &&
		push_ready ##1 fetch_addr_ff == 4'h0);
	c_lock: cover property ($rose(lock_ff));
	c_write_done: cover property ($fell(busy_ff));
	c_refused: cover property (ce && done_data && wen_ff && pe_s &&
		!all_ff && prot_vec[adr_ff]);

endmodule // swp_eeprom

// >>> tb/swp_host_model.sv
// Controller model that drives the serial link of the word store
module swp_host_model (
	// Clock
	clk,
	// Link pins
	cs,
	sk,
	di,
	dout
);
	timeunit 1ns;
	timeprecision 1ns;
	input  wire logic clk;
	output logic      cs;
	output logic      sk;
	output logic      di;
	input  wire logic dout;

	initial begin
		cs = 1'b0;
		sk = 1'b0;
		di = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Each clock level held five cycles, above the synchroniser minimum
	task automatic put(input logic b);
		sk <= 1'b0;
		di <= b;
		hold(5);
		sk <= 1'b1;
		hold(5);
	endtask

	// A fall presents the next bit; sample just before the next rise
	task automatic get(output logic b);
		sk <= 1'b0;
		hold(5);
		b = dout;
		sk <= 1'b1;
		hold(5);
	endtask

	task automatic frame(input logic [1:0] op, input logic [3:0] a,
		input logic [15:0] d, input int nd);
		cs <= 1'b1;
		hold(4);
		put(1'b1);
		for (int i = 1; i >= 0; i--) put(op[i]);
		for (int i = 3; i >= 0; i--) put(a[i]);
		for (int i = 15; i > 15 - nd; i--) put(d[i]);
	endtask

	// Released data line shows the inverse of its last bit, clock stays low
	task automatic stop();
		sk <= 1'b0;
		hold(1);
		cs <= 1'b0;
		di <= ~di;
		hold(4);
	endtask
endmodule // swp_host_model

// >>> tb/swp_eeprom_tb.sv
// Self-checking bench for the serial protected word store
module swp_eeprom_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WCYC = 8;
	// About 11300 cycles expected; cut off well beyond
	localparam int LIMIT_NS = 2000000;
	logic        clk, rst_n, ce, cs, sk, di, dout, dout_en, pe, pre;
	logic [15:0] mem [16];
	logic [15:0] pr_word;
	int          err_count, checks;

	swp_eeprom #(.WRITE_CYC(WCYC), .FIFO_DEPTH(swp_pkg::FIFO_DEPTH))
	swp_eeprom_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.chip_select_in(cs), .serial_clock_in(sk), .serial_data_in(di),
		.serial_data_out(dout), .serial_data_out_en(dout_en),
		.program_enable_in(pe), .protect_enable_in(pre));

	swp_host_model swp_host_model_inst (.clk(clk), .cs(cs), .sk(sk),
		.di(di), .dout(dout));

	always #20 clk = ~clk;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Instruction that may start a program; poll ready with select held
	task automatic prog(input logic p, input logic [1:0] op,
		input logic [3:0] a, input logic [15:0] d, input int nd,
		input logic t);
		int n;
		pre <= p;
		swp_host_model_inst.frame(op, a, d, nd);
		n = 0;
		while (dout !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check(16'(n >= WCYC - 4 && n <= WCYC + 1), 16'(t));
		check(16'(dout_en), 16'h0001);
		swp_host_model_inst.stop();
	endtask

	task automatic cmd(input logic p, input logic [3:0] a);
		pre <= p;
		swp_host_model_inst.frame(swp_pkg::OP_EXT, a, 16'h0, 0);
		swp_host_model_inst.stop();
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d,
		input logic t);
		prog(1'b0, swp_pkg::OP_WRITE, a, d, 16, t);
		if (t)
			mem[a] = d;
	endtask

	// Read n words from a, or the protect word when p is high
	task automatic rd(input logic p, input logic [3:0] a, input int n);
		logic [15:0] w;
		logic        b;
		pre <= p;
		swp_host_model_inst.frame(swp_pkg::OP_READ, a, 16'h0, 0);
		for (int k = 0; k < n; k++) begin
			for (int i = 15; i >= 0; i--) begin
				swp_host_model_inst.get(b);
				w[i] = b;
			end
			check(w, p ? pr_word : mem[4'(a + 4'(k))]);
		end
		swp_host_model_inst.stop();
	endtask

	task automatic t_refused();
		rd(1'b0, 4'h0, 2);
		pe <= 1'b1;
		wr(4'h5, 16'h1234, 1'b0);
		cmd(1'b0, {swp_pkg::EXT_ENABLE, 2'h0});
		pe <= 1'b0;
		wr(4'h5, 16'h1234, 1'b0);
		pe <= 1'b1;
	endtask

	task automatic t_write();
		wr(4'h5, 16'ha5a5, 1'b1);
		wr(4'h5, 16'h0f0f, 1'b1);
		wr(4'hf, 16'h1357, 1'b1);
		wr(4'h0, 16'h2468, 1'b1);
		rd(1'b0, 4'he, 3);
		rd(1'b0, 4'h5, 1);
	endtask

	task automatic t_protect();
		cmd(1'b1, {swp_pkg::EXT_ENABLE, 2'h0});
		prog(1'b1, swp_pkg::OP_WRITE, 4'h8, 16'h0, 0, 1'b1);
		wr(4'h8, 16'h5555, 1'b0);
		wr(4'hf, 16'h5555, 1'b0);
		wr(4'h7, 16'h6666, 1'b1);
		pr_word = 16'h4008;
		rd(1'b1, 4'h0, 1);
		rd(1'b0, 4'h7, 2);
	endtask

	task automatic t_all();
		prog(1'b0, swp_pkg::OP_EXT, {swp_pkg::EXT_WRALL, 2'h0},
			16'h00ff, 16, 1'b1);
		for (int i = 0; i < 8; i++)
			mem[i] = 16'h00ff;
		rd(1'b0, 4'h0, 16);
		cmd(1'b0, {swp_pkg::EXT_DISABLE, 2'h0});
		wr(4'h1, 16'hbeef, 1'b0);
	endtask

	task automatic t_lock();
		cmd(1'b0, {swp_pkg::EXT_ENABLE, 2'h0});
		prog(1'b1, swp_pkg::OP_CLEAR, swp_pkg::CLEAR_ADDR, 16'h0, 0,
			1'b1);
		wr(4'h8, 16'h8888, 1'b1);
		prog(1'b1, swp_pkg::OP_WRITE, 4'hc, 16'h0, 0, 1'b1);
		prog(1'b1, swp_pkg::OP_EXT, {swp_pkg::EXT_DISABLE, 2'h0},
			16'h0, 0, 1'b1);
		wr(4'h2, 16'h7777, 1'b0);
		prog(1'b1, swp_pkg::OP_CLEAR, swp_pkg::CLEAR_ADDR, 16'h0, 0,
			1'b0);
		pr_word = 16'hc00c;
		rd(1'b1, 4'h0, 1);
		rd(1'b0, 4'h0, 16);
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		pe = 1'b0;
		pre = 1'b0;
		err_count = 0;
		checks = 0;
		for (int i = 0; i < 16; i++)
			mem[i] = swp_pkg::MEM_RESET;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check(16'({dout, dout_en}), 16'h0);
		t_refused();
		t_write();
		t_protect();
		t_all();
		t_lock();
		finish_test();
	end

	initial begin
		#(LIMIT_NS);
		err_count++;
		finish_test();
	end
endmodule // swp_eeprom_tb
